// ==== logic/icec_params.svh ====
/*
 Constants of the configuration and EEPROM control unit: slave address,
 command codes, register indices, factory image, host map and timing.
 Assumes inclusion by the package, the checker and the testbench.
*/
`ifndef ICEC_PARAMS_SVH
`define ICEC_PARAMS_SVH

`define ICEC_SLAVE_ADDR          7'h6a
`define ICEC_CMD_WRITE           2'h0
`define ICEC_CMD_SAVE            2'h1
`define ICEC_CMD_RESTORE         2'h2
`define ICEC_NREG                16
`define ICEC_LAST_REG            4'hf
`define ICEC_REG_SLEEP_CTRL      4'h0
`define ICEC_SLEEP_INSTEAD_OF_POWERDOWN_BIT 0
`define ICEC_REG_STORED_SETUP_FIRST  4'h1
`define ICEC_REG_STORED_SETUP_SECOND 4'h2
`define ICEC_REG_STORED_SETUP_THIRD  4'h3
`define ICEC_FACTORY_BYTE        8'h14
`define ICEC_BIT_LAST            4'h8

`define ICEC_HOST_CTRL           8'h00
`define ICEC_HOST_TXDATA         8'h04
`define ICEC_HOST_RXDATA         8'h08
`define ICEC_HOST_STATUS         8'h0c
`define ICEC_CTRL_START          0
`define ICEC_CTRL_STOP           1
`define ICEC_CTRL_WRITE          2
`define ICEC_CTRL_READ           3
`define ICEC_CTRL_NACK           4

`define ICEC_CLK_NS              40
`define ICEC_QUARTER_NS          2500
`define ICEC_QUARTER_CYC ((`ICEC_QUARTER_NS + `ICEC_CLK_NS - 1) / `ICEC_CLK_NS)

`endif

// ==== logic/icec_pkg.sv ====
/*
 Types of the configuration and EEPROM control unit.
 Assumes icec_params.svh for all figures.
*/
`include "icec_params.svh"

package icec_pkg;

   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_RACK, D_BUSY} icec_dstate_t;
   typedef enum logic [1:0] {P_ADDR, P_CMD, P_PTR, P_DATA} icec_phase_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} icec_hstate_t;

   typedef logic [`ICEC_NREG-1:0][7:0] icec_bank_t;

   typedef struct packed {
      logic [1:0]   scl_m;
      logic [1:0]   sda_m;
      logic [1:0]   sel_m0;
      logic [1:0]   sel_m1;
      logic         scl_p;
      logic         sda_p;
      icec_dstate_t state;
      icec_phase_t  phase;
      logic [3:0]   cnt;
      logic [7:0]   sh;
      logic         rw;
      logic [1:0]   cmd;
      logic         pend;
      logic [1:0]   op;
      logic [7:0]   ptr;
      logic [3:0]   bidx;
      icec_bank_t   regs;
      icec_bank_t   eep;
      logic         sda_oe;
      logic [6:0]   out_en;
      logic         out_slow;
      logic         busy;
      logic [1:0]   setup;
   } icec_dev_t;

   typedef struct packed {
      logic [1:0]   sda_m;
      icec_hstate_t state;
      logic [1:0]   q;
      logic [7:0]   qcnt;
      logic [3:0]   bitn;
      logic [7:0]   sh;
      logic [7:0]   tx;
      logic [7:0]   rx;
      logic         f_stop;
      logic         f_byte;
      logic         f_read;
      logic         f_nack;
      logic         acked;
      logic         scl_oe;
      logic         sda_oe;
      logic [7:0]   rdata;
   } icec_host_t;

endpackage : icec_pkg

// ==== logic/icec_link_if.sv ====
/*
 Two-wire link between host end and device end.
 Assumes open-drain wiring: a line is low while any enable is high.
*/
`timescale 1ns/1ps

interface icec_link_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;

   // Wired-and of the open-drain lines
   assign scl = m_scl_oe ? m_scl_o : 1'b1;
   assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

   modport device (input scl, input sda, output d_sda_o, output d_sda_oe);
   modport host   (input scl, input sda, output m_scl_o, output m_scl_oe,
                   output m_sda_o, output m_sda_oe);
endinterface : icec_link_if

// ==== logic/icec_device.sv ====
/*
 Device end: two-wire slave, programming registers, EEPROM image with
 save and restore, power-up restore and setup selection by pins.
 Assumes the link through icec_link_if and select pins from off chip.
*/
// The address-and-strobe port and the address map are this design's own decisions.
// Function
// - Answer only slave address 1101010
// - Byte after address is command, pointer follows
// - Pointer steps after each byte moved
// - Acknowledge by holding data low
// - Master ends with stop or repeated start
// - Save and restore copy whole register bank
// - Save or restore: address, command, stop
// - Run after stop, no acknowledge while running
// - Others keep off the bus meanwhile
// - Restore automatically after power-up
// - Address acknowledge signals readiness
// - Select pins pick sleep or three setups
// - Sleep keeps only slow clock on two
// - Register writes accepted except while a save or restore runs
// - Select pins never both low at power-up
// - Command low bits: write, save, restore
// - Read: set pointer, restart, last byte nacked
// - Outputs off while restore runs
`timescale 1ns/1ps

module icec_device
   import icec_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   icec_link_if.device      link,
   input  wire logic [1:0]  sel_pins,
   output logic      [6:0]  out_enable,
   output logic             output_two_pin_slow,
   output logic             busy,
   output logic      [1:0]  active_setup
);
   import icec_pkg::*;

   icec_dev_t s_r;
   icec_dev_t s_nxt;
   logic      scl;
   logic      sda;
   logic      rise;
   logic      fall;
   logic      start;
   logic      stop;

   ////////////////////////////////////////////////////////////////////////////
   // Register read with zero beyond the bank
   function automatic logic [7:0] rd_byte(input icec_bank_t regs, input logic [7:0] ptr);
      if (ptr < 8'(`ICEC_NREG))
         rd_byte = regs[ptr[3:0]];
      else
         rd_byte = 8'h00;
   endfunction : rd_byte

   ////////////////////////////////////////////////////////////////////////////
   // Line events
   assign scl   = s_r.scl_m[1];
   assign sda   = s_r.sda_m[1];
   assign rise  = scl & ~s_r.scl_p;
   assign fall  = ~scl & s_r.scl_p;
   assign start = scl & s_r.scl_p & ~sda & s_r.sda_p;
   assign stop  = scl & s_r.scl_p & sda & ~s_r.sda_p;

   assign link.d_sda_o        = 1'b0;
   assign link.d_sda_oe       = s_r.sda_oe;
   assign out_enable          = s_r.out_en;
   assign output_two_pin_slow = s_r.out_slow;
   assign busy                = s_r.busy;
   assign active_setup        = s_r.setup;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic [7:0] b;
      b = 8'h00;
      s_nxt = s_r;
      s_nxt.scl_m  = {s_r.scl_m[0], link.scl};
      s_nxt.sda_m  = {s_r.sda_m[0], link.sda};
      s_nxt.sel_m0 = {s_r.sel_m0[0], sel_pins[0]};
      s_nxt.sel_m1 = {s_r.sel_m1[0], sel_pins[1]};
      s_nxt.scl_p  = scl;
      s_nxt.sda_p  = sda;

      case (s_r.state)
         D_BUSY:
         begin
            s_nxt.sda_oe = 1'b0;
            if (s_r.op == `ICEC_CMD_SAVE)
               s_nxt.eep[s_r.bidx] = s_r.regs[s_r.bidx];
            else
               s_nxt.regs[s_r.bidx] = s_r.eep[s_r.bidx];
            s_nxt.bidx = s_r.bidx + 4'h1;
            if (s_r.bidx == `ICEC_LAST_REG)
               s_nxt.state = D_IDLE;
         end
         D_RX:
         begin
            if (rise)
            begin
               s_nxt.sh  = {s_r.sh[6:0], sda};
               s_nxt.cnt = s_r.cnt + 4'h1;
            end
            else if (fall && s_r.cnt == `ICEC_BIT_LAST)
            begin
               s_nxt.sda_oe = 1'b1;
               s_nxt.state  = D_ACK;
               case (s_r.phase)
                  P_ADDR:
                  begin
                     if (s_r.sh[7:1] == `ICEC_SLAVE_ADDR)
                     begin
                        s_nxt.rw    = s_r.sh[0];
                        s_nxt.phase = P_CMD;
                     end
                     else
                     begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.state  = D_IDLE;
                     end
                  end
                  P_CMD:
                  begin
                     s_nxt.cmd   = s_r.sh[1:0];
                     s_nxt.pend  = (s_r.sh[1:0] == `ICEC_CMD_SAVE) ||
                                   (s_r.sh[1:0] == `ICEC_CMD_RESTORE);
                     s_nxt.phase = (s_r.sh[1:0] == `ICEC_CMD_WRITE) ? P_PTR : P_DATA;
                  end
                  P_PTR:
                  begin
                     s_nxt.ptr   = s_r.sh;
                     s_nxt.phase = P_DATA;
                  end
                  default:
                  begin
                     s_nxt.pend = 1'b0;
                     if (s_r.cmd == `ICEC_CMD_WRITE)
                     begin
                        if (s_r.ptr < 8'(`ICEC_NREG))
                           s_nxt.regs[s_r.ptr[3:0]] = s_r.sh;
                        s_nxt.ptr = s_r.ptr + 8'h01;
                     end
                  end
               endcase
            end
         end
         D_ACK, D_RACK:
         begin
            if (s_r.state == D_RACK && rise)
            begin
               if (sda)
                  s_nxt.state = D_IDLE;
               else
                  s_nxt.cnt = 4'h1;
            end
            else if (fall && (s_r.state == D_ACK || s_r.cnt == 4'h1))
            begin
               s_nxt.cnt = 4'h0;
               if (s_r.rw)
               begin
                  b            = rd_byte(s_r.regs, s_r.ptr);
                  s_nxt.sda_oe = ~b[7];
                  s_nxt.sh     = {b[6:0], 1'b0};
                  s_nxt.ptr    = s_r.ptr + 8'h01;
                  s_nxt.state  = D_TX;
               end
               else
               begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.state  = D_RX;
               end
            end
         end
         D_TX:
         begin
            if (rise)
               s_nxt.cnt = s_r.cnt + 4'h1;
            else if (fall)
            begin
               if (s_r.cnt == `ICEC_BIT_LAST)
               begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.cnt    = 4'h0;
                  s_nxt.state  = D_RACK;
               end
               else
               begin
                  s_nxt.sda_oe = ~s_r.sh[7];
                  s_nxt.sh     = {s_r.sh[6:0], 1'b0};
               end
            end
         end
         default:
         begin
            s_nxt.sda_oe = 1'b0;
         end
      endcase

      if (s_r.state != D_BUSY)
      begin
         if (start)
         begin
            s_nxt.state  = D_RX;
            s_nxt.phase  = P_ADDR;
            s_nxt.cnt    = 4'h0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.pend   = 1'b0;
         end
         else if (stop)
         begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.pend   = 1'b0;
            s_nxt.bidx   = 4'h0;
            s_nxt.op     = s_r.cmd;
            s_nxt.state  = s_r.pend ? D_BUSY : D_IDLE;
         end
      end

      s_nxt.setup = {s_r.sel_m1[1], s_r.sel_m0[1]};
      s_nxt.busy  = (s_r.state == D_BUSY);
      if (s_r.state == D_BUSY && s_r.op != `ICEC_CMD_SAVE)
      begin
         s_nxt.out_en   = 7'h00;
         s_nxt.out_slow = 1'b0;
      end
      else if (s_r.setup == 2'h0)
      begin
         s_nxt.out_en   = 7'h00;
         s_nxt.out_slow =
            s_r.regs[`ICEC_REG_SLEEP_CTRL][`ICEC_SLEEP_INSTEAD_OF_POWERDOWN_BIT];
      end
      else
      begin
         s_nxt.out_en   = s_r.regs[{2'h0, s_r.setup}][6:0];
         s_nxt.out_slow = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         s_r       <= '0;
         s_r.scl_m <= 2'h3;
         s_r.sda_m <= 2'h3;
         s_r.scl_p <= 1'b1;
         s_r.sda_p <= 1'b1;
         s_r.state <= D_BUSY;
         s_r.op    <= `ICEC_CMD_RESTORE;
         s_r.busy  <= 1'b1;
         s_r.setup <= 2'h1;
         s_r.eep   <= {`ICEC_NREG{`ICEC_FACTORY_BYTE}};
      end
      else
         s_r <= s_nxt;
   end

endmodule : icec_device

// ==== logic/icec_host.sv ====
/*
 Host end: two-wire bus master driven by a small register port.
 Assumes software issues one action at a time and polls the busy bit.
*/
`timescale 1ns/1ps

module icec_host
   import icec_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   icec_link_if.host        link,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata
);
   import icec_pkg::*;

   localparam logic [7:0] QUARTER = 8'(`ICEC_QUARTER_CYC);

   icec_host_t s_r;
   icec_host_t s_nxt;
   logic       sda;
   logic       tick;

   assign sda           = s_r.sda_m[1];
   assign tick          = (s_r.qcnt == QUARTER - 8'h01);
   assign link.m_scl_o  = 1'b0;
   assign link.m_sda_o  = 1'b0;
   assign link.m_scl_oe = s_r.scl_oe;
   assign link.m_sda_oe = s_r.sda_oe;
   assign rdata         = s_r.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.sda_m = {s_r.sda_m[0], link.sda};

      if (rd)
      begin
         if (addr == `ICEC_HOST_RXDATA)
            s_nxt.rdata = s_r.rx;
         else if (addr == `ICEC_HOST_STATUS)
            s_nxt.rdata = {6'h00, s_r.acked, s_r.state != H_IDLE};
         else if (addr == `ICEC_HOST_TXDATA)
            s_nxt.rdata = s_r.tx;
         else
            s_nxt.rdata = 8'h00;
      end

      if (wr && addr == `ICEC_HOST_TXDATA)
         s_nxt.tx = wdata;

      if (s_r.state == H_IDLE)
      begin
         s_nxt.qcnt = 8'h00;
         s_nxt.q    = 2'h0;
         if (wr && addr == `ICEC_HOST_CTRL)
         begin
            s_nxt.f_stop = wdata[`ICEC_CTRL_STOP];
            s_nxt.f_read = wdata[`ICEC_CTRL_READ];
            s_nxt.f_byte = wdata[`ICEC_CTRL_READ] | wdata[`ICEC_CTRL_WRITE];
            s_nxt.f_nack = wdata[`ICEC_CTRL_NACK];
            s_nxt.sh     = wdata[`ICEC_CTRL_READ] ? 8'hff : s_r.tx;
            s_nxt.bitn   = 4'h0;
            if (wdata[`ICEC_CTRL_START])
               s_nxt.state = H_START;
            else if (wdata[`ICEC_CTRL_READ] | wdata[`ICEC_CTRL_WRITE])
               s_nxt.state = H_BIT;
            else if (wdata[`ICEC_CTRL_STOP])
               s_nxt.state = H_STOP;
         end
      end
      else
      begin
         s_nxt.qcnt = tick ? 8'h00 : s_r.qcnt + 8'h01;
         if (tick)
         begin
            s_nxt.q = s_r.q + 2'h1;
            case (s_r.state)
               H_START:
               begin
                  case (s_r.q)
                     2'h0: s_nxt.sda_oe = 1'b0;
                     2'h1: s_nxt.scl_oe = 1'b0;
                     2'h2: s_nxt.sda_oe = 1'b1;
                     default:
                     begin
                        s_nxt.scl_oe = 1'b1;
                        s_nxt.state  = s_r.f_byte ? H_BIT : (s_r.f_stop ? H_STOP : H_IDLE);
                     end
                  endcase
               end
               H_BIT:
               begin
                  case (s_r.q)
                     2'h0:
                     begin
                        if (s_r.bitn < `ICEC_BIT_LAST)
                           s_nxt.sda_oe = ~s_r.sh[7];
                        else
                           s_nxt.sda_oe = s_r.f_read & ~s_r.f_nack;
                     end
                     2'h1: s_nxt.scl_oe = 1'b0;
                     2'h2:
                     begin
                        if (s_r.bitn < `ICEC_BIT_LAST)
                           s_nxt.sh = {s_r.sh[6:0], sda};
                        else
                           s_nxt.acked = ~sda;
                     end
                     default:
                     begin
                        s_nxt.scl_oe = 1'b1;
                        s_nxt.bitn   = s_r.bitn + 4'h1;
                        if (s_r.bitn == `ICEC_BIT_LAST)
                        begin
                           s_nxt.sda_oe = 1'b0;
                           s_nxt.rx     = s_r.sh;
                           s_nxt.state  = s_r.f_stop ? H_STOP : H_IDLE;
                        end
                     end
                  endcase
               end
               default:
               begin
                  case (s_r.q)
                     2'h0: s_nxt.sda_oe = 1'b1;
                     2'h1: s_nxt.scl_oe = 1'b0;
                     2'h2: s_nxt.sda_oe = 1'b0;
                     default: s_nxt.state = H_IDLE;
                  endcase
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         s_r       <= '0;
         s_r.sda_m <= 2'h3;
      end
      else
         s_r <= s_nxt;
   end

endmodule : icec_host

// ==== verif/icec_link_properties.sv ====
/*
 Checker of the two-wire link between host end and device end.
 Assumes the link lines and the device busy flag as plain inputs.
*/
`timescale 1ns/1ps
`include "icec_params.svh"

module icec_link_properties (
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       m_sda_oe,
   input wire logic       d_sda_oe,
   input wire logic       busy
);
   logic       scl_q;
   logic       sda_q;
   logic       first;
   logic [3:0] nbit;
   logic [7:0] sh;
   logic       start_c;
   logic       rise_c;
   logic       ninth;

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////////////////
   // Bit and byte tracking
   assign start_c = scl && scl_q && sda_q && !sda;
   assign rise_c  = scl && !scl_q;
   assign ninth   = rise_c && first && (nbit == `ICEC_BIT_LAST);

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         first <= 1'b0;
         nbit  <= 4'h0;
         sh    <= 8'h00;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_c)
         begin
            first <= 1'b1;
            nbit  <= 4'h0;
         end
         else if (rise_c)
         begin
            sh    <= (nbit < `ICEC_BIT_LAST) ? {sh[6:0], sda} : sh;
            nbit  <= (nbit == `ICEC_BIT_LAST) ? 4'h0 : nbit + 4'h1;
            first <= (nbit == `ICEC_BIT_LAST) ? 1'b0 : first;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_foreign_addr_quiet : assert property (
      ninth && (sh[7:1] != `ICEC_SLAVE_ADDR) |-> !d_sda_oe)
      else $error("device acknowledged a foreign address");
   a_addr_bits_free : assert property (
      rise_c && first && (nbit < `ICEC_BIT_LAST) |-> !d_sda_oe)
      else $error("device drives data during the address byte");
   a_host_frees_ack : assert property (
      ninth |-> !m_sda_oe)
      else $error("host drives data during the address acknowledge");
   a_dev_stable_high : assert property (
      scl && scl_q |-> $stable(d_sda_oe))
      else $error("device changed data while clock high");
   a_start_by_host : assert property (
      $fell(sda) && scl && scl_q |-> m_sda_oe)
      else $error("start condition not made by host");
   a_busy_bus_idle : assert property (
      $rose(busy) |-> $past(scl) && $past(sda))
      else $error("copy started while bus not idle");
   a_busy_sixteen : assert property (
      $rose(busy) |-> busy[*8] ##1 busy[*8] ##1 !busy)
      else $error("copy did not last sixteen cycles");
   a_boot_restore : assert property (
      $rose(reset_n) |-> ##[0:2] busy)
      else $error("no restore after reset");

   c_own_ack  : cover property (ninth && d_sda_oe);
   c_foreign  : cover property (ninth && !d_sda_oe);
   c_copy_run : cover property ($rose(busy));
endmodule : icec_link_properties

// ==== verif/icec_tb.sv ====
/*
 Testbench: host end and device end joined by the link, host driven
 through its register port. Assumes the design files compiled first.
*/
`timescale 1ns/1ps
`include "icec_params.svh"

module icec_tb;
   import icec_pkg::*;
   localparam logic [7:0] AW = {`ICEC_SLAVE_ADDR, 1'b0};
   localparam logic [7:0] AR = {`ICEC_SLAVE_ADDR, 1'b1};
   logic       clock    = 1'b0;
   logic       reset_n  = 1'b0;
   logic [1:0] sel_pins = 2'b01;
   logic [7:0] addr     = 8'h00;
   logic [7:0] wdata    = 8'h00;
   logic       wr       = 1'b0;
   logic       rd       = 1'b0;
   logic       rd_c     = 1'b0;
   logic       rd_q     = 1'b0;
   logic [7:0] rdata;
   logic [6:0] out_enable;
   logic       slow;
   logic       busy;
   logic [1:0] act_setup;
   logic [7:0] exp_q[$];
   logic [7:0] regs_e[0:3];
   int         n_errors = 0;
   int         checked  = 0;

   icec_link_if link ();
   icec_device i_icec_device (.clock(clock), .reset_n(reset_n), .link(link),
      .sel_pins(sel_pins), .out_enable(out_enable), .output_two_pin_slow(slow),
      .busy(busy), .active_setup(act_setup));
   icec_host i_icec_host (.clock(clock), .reset_n(reset_n), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   icec_link_properties i_icec_link_properties (.clock(clock), .reset_n(reset_n),
      .scl(link.scl), .sda(link.sda), .m_sda_oe(link.m_sda_oe),
      .d_sda_oe(link.d_sda_oe), .busy(busy));

   always #20 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // Reporting
   task automatic print_verdict;
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic check_rd(input logic [7:0] got, input logic [7:0] e);
      checked++;
      if (got !== e)
      begin
         n_errors++;
         $display("mismatch %0t read %h expected %h", $time, got, e);
      end
   endtask : check_rd

   task automatic check_out(input logic [7:0] e);
      checked++;
      if ({slow, out_enable} !== e)
      begin
         n_errors++;
         $display("mismatch %0t outputs %h expected %h", $time, {slow, out_enable}, e);
      end
   endtask : check_out

   task automatic check_sel(input logic [1:0] e);
      checked++;
      if (act_setup !== e)
      begin
         n_errors++;
         $display("mismatch %0t setup %h expected %h", $time, act_setup, e);
      end
   endtask : check_sel

   always @(posedge clock)
   begin
      rd_q <= rd & rd_c;
      if (rd_q)
         check_rd(rdata, exp_q.pop_front());
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port and bus actions
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic chk, input logic [7:0] e,
                         output logic [7:0] v);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      rd_c <= chk;
      if (chk)
         exp_q.push_back(e);
      @(posedge clock);
      rd   <= 1'b0;
      #1;
      v = rdata;
   endtask : reg_rd

   task automatic xfer(input logic [7:0] ctrl, input logic [7:0] tx, input logic ack);
      logic [7:0] v;
      int         n;
      reg_wr(`ICEC_HOST_TXDATA, tx);
      reg_wr(`ICEC_HOST_CTRL, ctrl);
      repeat (2) @(posedge clock);
      v = 8'h01;
      n = 0;
      while (v[0] && n < 3000)
      begin
         reg_rd(`ICEC_HOST_STATUS, 1'b0, 8'h00, v);
         n++;
      end
      reg_rd(`ICEC_HOST_STATUS, 1'b1, {6'h00, ack, 1'b0}, v);
   endtask : xfer

   task automatic dev_ptr(input logic [7:0] p);
      xfer(8'h05, AW, 1'b1);
      xfer(8'h04, {6'($urandom), `ICEC_CMD_WRITE}, 1'b1);
      xfer(8'h04, p, 1'b1);
   endtask : dev_ptr

   task automatic settle_out(input logic [1:0] s, input logic [7:0] e);
      @(posedge clock);
      sel_pins <= s;
      repeat (8) @(posedge clock);
      #1;
      check_out(e);
      check_sel(s);
   endtask : settle_out

   ////////////////////////////////////////////////////////////////////////////
   // Tests
   initial
   begin
      logic [7:0] v;
      void'($urandom(32'hc814));
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check_out(8'h00);
      repeat (40) @(posedge clock);
      #1;
      check_out(`ICEC_FACTORY_BYTE & 8'h7f);
      settle_out(2'b00, 8'h00);
      xfer(8'h07, {7'h55, 1'b0}, 1'b0);
      for (int i = 0; i < 4; i++)
         regs_e[i] = 8'($urandom);
      regs_e[0][0] = 1'b1;
      dev_ptr(8'h00);
      for (int i = 0; i < 4; i++)
         xfer((i == 3) ? 8'h06 : 8'h04, regs_e[i], 1'b1);
      for (int s = 0; s < 4; s++)
         settle_out(2'(s), (s == 0) ? {regs_e[0][0], 7'h00} : {1'b0, regs_e[s][6:0]});
      dev_ptr(8'h01);
      xfer(8'h05, AR, 1'b1);
      for (int i = 1; i < 4; i++)
      begin
         xfer((i == 3) ? 8'h1a : 8'h08, 8'h00, i != 3);
         reg_rd(`ICEC_HOST_RXDATA, 1'b1, regs_e[i], v);
      end
      xfer(8'h05, AW, 1'b1);
      xfer(8'h06, {6'($urandom), `ICEC_CMD_SAVE}, 1'b1);
      dev_ptr(8'h01);
      xfer(8'h06, ~regs_e[1], 1'b1);
      xfer(8'h05, AW, 1'b1);
      xfer(8'h06, {6'($urandom), `ICEC_CMD_RESTORE}, 1'b1);
      dev_ptr(8'h01);
      xfer(8'h05, AR, 1'b1);
      xfer(8'h1a, 8'h00, 1'b0);
      reg_rd(`ICEC_HOST_RXDATA, 1'b1, regs_e[1], v);
      repeat (4) @(posedge clock);
      print_verdict();
   end

   initial
   begin
      repeat (90000) @(posedge clock);
      n_errors++;
      $display("mismatch %0t watchdog expired", $time);
      print_verdict();
   end
endmodule : icec_tb
